// ---- rtl/pes_supervisor.sv ----
// module: enable, power-good and reset supervisor of a multi-rail supply
// Function
// - control bit 3 selects low-ripple pfm
// - bias 170 us, then 750 us soft-start
// - discharge off at reset, active while disabled
// - rail low flags shown in status
// - interrupt when a monitored rail falls low
// - disabled rail reports power good
// - one pin enables both linears, software gates
// - lockout or overheat shuts every regulator
// - lockout disables all converters and linears
// - buck enable pin low disables its converter
// - buck1 default 1.2 V or 1.6 V
// - buck2 and buck3 default 1.8 V or 3.3 V
// - warm reset pulls reset, restores buck1 only
// - warm reset accepted after 30 ms filter
// - reset held while clock rail low, then delay
// - reset output is open drain
// - supply-fail and battery-low flags reported
// - buck1 defaults on warm, rail, lockout, reset
// - linear select pins latched at power-up
// - linear voltages reprogrammable after power-up
// - off mode under lockout, regulators on-mode only
// - enable is bit and pin; bits reset high
// - mask bit stops flag reaching interrupt
// - interrupt low while enabled rail out
`default_nettype none
module pes_supervisor #(
  parameter int unsigned RESET_CAP_NF = 1, // delay capacitor value
  parameter int unsigned RESET_TICKS = pes_pkg::RESET_TICKS_PER_NF *
    RESET_CAP_NF,                        // reset release delay in ticks
  parameter int unsigned WARM_TICKS = pes_pkg::WARM_TICKS, // warm filter
  parameter int unsigned LF_DIV = pes_pkg::LF_DIV // oscillator divider
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pes_pkg::pes_analog_t analog_i,   // comparator results
  input wire logic buck1_enable_pin_i,
  input wire logic buck2_enable_pin_i,
  input wire logic buck3_enable_pin_i,
  input wire logic linear_regs_enable_pin_i,
  input wire logic buck1_default_sel_i,
  input wire logic buck2_default_sel_i,
  input wire logic buck3_default_sel_i,
  input wire logic linear_default_sel_a_i,
  input wire logic linear_default_sel_b_i,
  input wire logic warm_reset_in_i,            // high active warm reset
  input wire logic [7:0] converter_control_reg_i, // converter control
  input wire logic [7:0] discharge_control_reg_i, // discharge per buck
  input wire logic [7:0] mask_wdata_i,         // mask value to write
  input wire logic mask_we_i,                  // mask write strobe
  input wire logic [7:0] enable_wdata_i,       // enable bits to write
  input wire logic enable_we_i,                // enable write strobe
  input wire logic [11:0] lin_one_wdata_i,     // linear one voltage
  input wire logic lin_one_we_i,
  input wire logic [11:0] lin_two_wdata_i,     // linear two voltage
  input wire logic lin_two_we_i,
  input wire logic [11:0] buck1_wdata_i,       // buck1 core voltage
  input wire logic buck1_we_i,
  output logic [2:0] buck_enable_o,            // buck 3..1 run
  output logic [2:0] buck_switch_o,            // buck 3..1 switching
  output logic [2:0] buck_soft_start_o,        // buck 3..1 ramping
  output logic [2:0] buck_discharge_o,         // buck 3..1 discharge
  output logic low_ripple_o,                   // low-ripple pfm
  output logic [1:0] linear_enable_o,          // linear two..one run
  output logic [4:0] comparator_on_o,          // power-good comp enable
  output pes_pkg::pes_volt_t volt_o,           // voltage targets
  output logic [7:0] power_not_good_status_o,  // status word
  output logic [7:0] mask_o,                   // mask readback
  output logic [7:0] enable_bits_o,            // enable readback
  output logic on_mode_o,                      // device in on mode
  output logic supply_fail_flag_o,
  output logic battery_low_flag_o,
  output logic int_n_o,                        // interrupt, low active
  output logic system_reset_out_o,             // pin drive level, low
  output logic system_reset_out_oe_n_o         // low while pulling low
);
  // ---- oscillator divider
  logic [15:0] div_count; // cycles into current tick
  wire tick = (div_count == 16'(LF_DIV - 1));
  always_ff @(posedge mclk_i) begin
    if (rst_i || tick) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 16'h0001;
    end
  end

  // ---- mode and shutdown
  wire lockout = analog_i.supply_low;
  wire on_mode = !lockout;
  wire shut_all = lockout || analog_i.over_temp;
  assign on_mode_o = on_mode;

  // ---- software enable bits
  logic [7:0] enable_bits; // software enable register
  logic [7:0] next_enable_bits;
  wire [7:0] pin_vec = {2'b11, buck1_enable_pin_i, buck2_enable_pin_i,
    buck3_enable_pin_i, linear_regs_enable_pin_i, linear_regs_enable_pin_i,
    1'b1};
  // write first, then force bits high where the pin is low
  assign next_enable_bits = lockout ? pes_pkg::ENABLE_RESET :
    ((enable_we_i ? enable_wdata_i : enable_bits) | ~pin_vec);
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      enable_bits <= pes_pkg::ENABLE_RESET;
    end else begin
      enable_bits <= next_enable_bits;
    end
  end
  assign enable_bits_o = enable_bits;

  // ---- effective enables: bit and pin, gated by shutdown
  wire [4:0] rail_en; // buck1,buck2,buck3,lin_two,lin_one
  assign rail_en = (enable_bits[5:1] & pin_vec[5:1]) &
    {5{!shut_all}};
  // rail_en keeps buck1 in bit 4, which is also bit 2 of the 3..1 output
  assign buck_enable_o = rail_en[4:2];
  assign linear_enable_o = rail_en[1:0];

  // ---- per-buck start phase: bias delay then soft-start
  pes_pkg::pes_phase_t phase [3]; // index 0 = buck1
  logic [2:0] bias_done;
  logic [2:0] ramp_done;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_buck
      wire en = rail_en[4-g];
      pes_tick_count #(.W(16)) u_bias (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .run_i(en && phase[g] == pes_pkg::PES_BIAS),
        .tick_i(tick), .limit_i(16'(pes_pkg::BIAS_TICKS)),
        .done_o(bias_done[g]));
      pes_tick_count #(.W(16)) u_ramp (
        .mclk_i(mclk_i), .rst_i(rst_i),
        .run_i(en && phase[g] == pes_pkg::PES_RAMP),
        .tick_i(tick), .limit_i(16'(pes_pkg::SOFT_TICKS)),
        .done_o(ramp_done[g]));
      // phase sequence, back to off on any disable
      always_ff @(posedge mclk_i) begin
        if (rst_i || !en) begin
          phase[g] <= pes_pkg::PES_OFF;
        end else begin
          unique case (phase[g])
            pes_pkg::PES_OFF: phase[g] <= pes_pkg::PES_BIAS;
            pes_pkg::PES_BIAS: if (bias_done[g]) begin
              phase[g] <= pes_pkg::PES_RAMP;
            end
            pes_pkg::PES_RAMP: if (ramp_done[g]) begin
              phase[g] <= pes_pkg::PES_RUN;
            end
            pes_pkg::PES_RUN: phase[g] <= pes_pkg::PES_RUN;
          endcase
        end
      end
      // index 2 is buck1 in the 3..1 output order
      assign buck_switch_o[2-g] = (phase[g] == pes_pkg::PES_RAMP) ||
        (phase[g] == pes_pkg::PES_RUN);
      assign buck_soft_start_o[2-g] = (phase[g] == pes_pkg::PES_RAMP);
      // discharge while disabled, if chosen per buck
      assign buck_discharge_o[2-g] = !en &&
        discharge_control_reg_i[g];
    end
  endgenerate

  assign low_ripple_o =
    converter_control_reg_i[pes_pkg::CONV_LOW_RIPPLE_BIT];

  // ---- power-good comparators and status
  assign comparator_on_o = rail_en;
  wire [4:0] rail_bad = analog_i.rail_low & rail_en;
  logic [7:0] status; // registered status word
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status <= 8'h00;
    end else begin
      status <= {analog_i.supply_fail, analog_i.battery_low,
        rail_bad, 1'b0};
    end
  end
  assign power_not_good_status_o = status;
  assign supply_fail_flag_o = status[pes_pkg::PNG_SUPPLY_FAIL];
  assign battery_low_flag_o = status[pes_pkg::PNG_BATT_LOW];

  // ---- interrupt mask
  logic [7:0] mask; // mask register
  always_ff @(posedge mclk_i) begin
    if (rst_i || lockout) begin
      mask <= pes_pkg::MASK_RESET;
    end else if (mask_we_i) begin
      mask <= mask_wdata_i;
    end
  end
  assign mask_o = mask;
  // low while any unmasked flag, or when nothing is enabled
  logic int_n; // registered interrupt level
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_n <= 1'b0;
    end else begin
      int_n <= !(|(status & ~mask)) && (|rail_en);
    end
  end
  assign int_n_o = int_n;

  // ---- warm reset filter
  logic warm_ok; // filtered warm reset
  pes_tick_count #(.W(16)) u_warm (
    .mclk_i(mclk_i), .rst_i(rst_i), .run_i(warm_reset_in_i),
    .tick_i(tick), .limit_i(16'(WARM_TICKS)), .done_o(warm_ok));

  // ---- system reset delay after clock rail rises
  logic rail_delay_done;
  pes_tick_count #(.W(24)) u_rst (
    .mclk_i(mclk_i), .rst_i(rst_i), .run_i(analog_i.clock_rail_ok),
    .tick_i(tick), .limit_i(24'(RESET_TICKS)),
    .done_o(rail_delay_done));
  wire reset_active = !rail_delay_done || warm_ok;
  logic sys_reset; // registered reset state, high = asserted
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sys_reset <= 1'b1;
    end else begin
      sys_reset <= reset_active;
    end
  end
  // open drain: pull low when asserted, else release
  assign system_reset_out_o = 1'b0;
  assign system_reset_out_oe_n_o = !sys_reset;

  // ---- default voltages
  wire [11:0] buck1_def = buck1_default_sel_i ?
    pes_pkg::MV_1600 : pes_pkg::MV_1200;
  wire [11:0] buck2_def = buck2_default_sel_i ?
    pes_pkg::MV_3300 : pes_pkg::MV_1800;
  wire [11:0] buck3_def = buck3_default_sel_i ?
    pes_pkg::MV_3300 : pes_pkg::MV_1800;
  wire [1:0] lin_sel = {linear_default_sel_b_i, linear_default_sel_a_i};
  wire [11:0] lin_one_def = (lin_sel == 2'h1) ? pes_pkg::MV_2800 :
    (lin_sel == 2'h3) ? pes_pkg::MV_1800 : pes_pkg::MV_1300;
  wire [11:0] lin_two_def = (lin_sel == 2'h2) ? pes_pkg::MV_1800 :
    pes_pkg::MV_3300;

  // ---- buck1 voltage, back to default on any reset source
  wire buck1_restore = warm_ok || !analog_i.clock_rail_ok || lockout ||
    sys_reset;
  logic [11:0] buck1_v; // buck1 target
  always_ff @(posedge mclk_i) begin
    if (rst_i || buck1_restore) begin
      buck1_v <= buck1_def;
    end else if (buck1_we_i) begin
      buck1_v <= buck1_wdata_i;
    end
  end

  // ---- linear voltages: latch at power-up, then writable
  logic latched; // power-up latch taken
  logic [11:0] lin_one_v;
  logic [11:0] lin_two_v;
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      latched <= 1'b0;
    end else begin
      latched <= 1'b1;
    end
  end
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lin_one_v <= pes_pkg::MV_1300;
      lin_two_v <= pes_pkg::MV_3300;
    end else if (!latched) begin
      lin_one_v <= lin_one_def;
      lin_two_v <= lin_two_def;
    end else begin
      if (lin_one_we_i) begin
        lin_one_v <= lin_one_wdata_i;
      end
      if (lin_two_we_i) begin
        lin_two_v <= lin_two_wdata_i;
      end
    end
  end

  assign volt_o = '{buck1: buck1_v, buck2: buck2_def, buck3: buck3_def,
    lin_one: lin_one_v, lin_two: lin_two_v};
endmodule : pes_supervisor
`default_nettype wire

// ---- rtl/pes_pkg.sv ----
// package: constants and carrier types for the enable and reset supervisor
`default_nettype none
package pes_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 100_000_000;
  // low-frequency timing oscillator rate, derived by a divider
  localparam int unsigned LF_HZ = 32_000;
  localparam int unsigned LF_DIV = CLK_HZ / LF_HZ;
  // delays in microseconds and milliseconds, as printed
  localparam int unsigned BIAS_DELAY_US = 170;
  localparam int unsigned SOFT_START_US = 750;
  localparam int unsigned WARM_FILTER_MS = 30;
  localparam int unsigned RESET_PER_NF_MS = 100;
  // delays in low-frequency ticks, rounded up
  localparam int unsigned BIAS_TICKS =
    (BIAS_DELAY_US * LF_HZ + 999_999) / 1_000_000;
  localparam int unsigned SOFT_TICKS =
    (SOFT_START_US * LF_HZ + 999_999) / 1_000_000;
  localparam int unsigned WARM_TICKS = (WARM_FILTER_MS * LF_HZ + 999) / 1000;
  localparam int unsigned RESET_TICKS_PER_NF =
    (RESET_PER_NF_MS * LF_HZ + 999) / 1000;
  // bit positions in converter control
  localparam int unsigned CONV_LOW_RIPPLE_BIT = 3;
  // bit positions of the two flags and five rails in the status word
  localparam int unsigned PNG_SUPPLY_FAIL = 7;
  localparam int unsigned PNG_BATT_LOW = 6;
  localparam int unsigned PNG_BUCK1 = 5;
  localparam int unsigned PNG_BUCK2 = 4;
  localparam int unsigned PNG_BUCK3 = 3;
  localparam int unsigned PNG_LIN_TWO = 2;
  localparam int unsigned PNG_LIN_ONE = 1;
  // reset values
  localparam logic [7:0] ENABLE_RESET = 8'hFF;
  localparam logic [7:0] MASK_RESET = 8'hC0;
  localparam logic [7:0] DISCHARGE_RESET = 8'h00;
  // voltage codes in millivolts
  localparam logic [11:0] MV_1200 = 12'h4B0;
  localparam logic [11:0] MV_1300 = 12'h514;
  localparam logic [11:0] MV_1600 = 12'h640;
  localparam logic [11:0] MV_1800 = 12'h708;
  localparam logic [11:0] MV_2800 = 12'hAF0;
  localparam logic [11:0] MV_3300 = 12'hCE4;
  // per-converter start phase
  typedef enum logic [1:0] {PES_OFF, PES_BIAS, PES_RAMP, PES_RUN} pes_phase_t;
  // analog comparator results from the front end
  typedef struct packed {
    logic supply_low;     // main supply under lockout threshold
    logic over_temp;      // junction above shutdown temperature
    logic clock_rail_ok;  // clock rail above reset release level
    logic supply_fail;    // supply-fail sense below 1 V
    logic battery_low;    // battery-low sense below 1 V
    logic [4:0] rail_low; // rail under power-good threshold, bit per rail
  } pes_analog_t;
  // voltage targets handed to the analog loops
  typedef struct packed {
    logic [11:0] buck1;
    logic [11:0] buck2;
    logic [11:0] buck3;
    logic [11:0] lin_one;
    logic [11:0] lin_two;
  } pes_volt_t;
endpackage : pes_pkg
`default_nettype wire

// ---- rtl/pes_tick_count.sv ----
// module: counter of low-frequency ticks with a terminal flag
`default_nettype none
module pes_tick_count #(
  parameter int unsigned W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic run_i,        // count while high, clear while low
  input wire logic tick_i,       // low-frequency enable pulse
  input wire logic [W-1:0] limit_i, // terminal count
  output logic done_o            // high once limit reached
);
  logic [W-1:0] count; // ticks seen so far
  logic [W-1:0] next_count;
  wire at_limit = (count >= limit_i);
  assign done_o = run_i && at_limit;
  // saturating count up
  assign next_count = !run_i ? '0 :
    (tick_i && !at_limit) ? W'(count + 1'b1) : count;
  // count register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : pes_tick_count
`default_nettype wire

// ---- verif/pes_sva.sv ----
// checker: port-level properties of the enable and reset supervisor
`default_nettype none
module pes_sva (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire pes_pkg::pes_analog_t analog_i,
  input wire logic buck1_enable_pin_i,
  input wire logic warm_reset_in_i,
  input wire logic [7:0] converter_control_reg_i,
  input wire logic [7:0] discharge_control_reg_i,
  input wire logic [2:0] buck_enable_o,
  input wire logic [2:0] buck_discharge_o,
  input wire logic low_ripple_o,
  input wire logic [1:0] linear_enable_o,
  input wire logic [4:0] comparator_on_o,
  input wire logic [7:0] power_not_good_status_o,
  input wire logic int_n_o,
  input wire logic on_mode_o,
  input wire logic system_reset_out_o,
  input wire logic system_reset_out_oe_n_o
);
  // one clock domain; reset aborts every check
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_lockout_all_off: assert property (
    analog_i.supply_low || analog_i.over_temp |->
    buck_enable_o == 3'h0 && linear_enable_o == 2'h0)
    else $error("regulator on under lockout");
  a_pin_gates_buck: assert property (
    !buck1_enable_pin_i |-> !buck_enable_o[2])
    else $error("buck1 on with pin low");
  a_ripple_follows: assert property (
    low_ripple_o == converter_control_reg_i[3])
    else $error("low ripple not bit 3");
  a_discharge_off: assert property (
    discharge_control_reg_i[2:0] == 3'h0 |-> buck_discharge_o == 3'h0)
    else $error("discharge while not selected");
  a_discharge_idle: assert property (
    discharge_control_reg_i[2:0] == 3'h7 |-> buck_discharge_o == ~buck_enable_o)
    else $error("discharge not tied to disable");
  a_disabled_good: assert property (
    comparator_on_o == 5'h0 |=> power_not_good_status_o[5:1] == 5'h0)
    else $error("disabled rail reads bad");
  a_fail_flag: assert property (
    analog_i.supply_fail |=> power_not_good_status_o[7])
    else $error("supply fail flag missing");
  a_int_power_ok: assert property (
    (comparator_on_o != 5'h0 && analog_i.rail_low == 5'h0 &&
    !analog_i.supply_fail && !analog_i.battery_low) [*2] |=> int_n_o)
    else $error("interrupt low with rails good");
  a_int_none_on: assert property (
    comparator_on_o == 5'h0 |=> !int_n_o)
    else $error("interrupt high with no rail");
  a_on_mode: assert property (
    on_mode_o == !analog_i.supply_low)
    else $error("mode wrong");
  a_open_drain: assert property (
    system_reset_out_o == 1'b0)
    else $error("reset pin drives high");
  a_rail_low_reset: assert property (
    !analog_i.clock_rail_ok |=> !system_reset_out_oe_n_o)
    else $error("reset released with rail low");
  a_reset_hold: assert property (
    $rose(analog_i.clock_rail_ok) |=> !system_reset_out_oe_n_o [*8])
    else $error("reset released too early");
  a_reset_free: assert property (
    $rose(analog_i.clock_rail_ok) |-> ##[1:60] (system_reset_out_oe_n_o ||
    !analog_i.clock_rail_ok || warm_reset_in_i))
    else $error("reset never released");
endmodule // pes_sva
`default_nettype wire

// ---- verif/pes_host.sv ----
// host model: drives enable pins, watches the wired reset line
`default_nettype none
module pes_host (
  input wire logic mclk_i,
  input wire logic [3:0] want_i,   // wanted: linear, buck3, buck2, buck1
  input wire logic reset_line_i,   // wired reset level
  output logic [3:0] pins_o        // enable pins, same order
);
  // pins start low; host is idle while held in reset
  initial pins_o = 4'h0;
  // each pin driven on its own, only once reset is released
  always @(posedge mclk_i) begin
    pins_o <= reset_line_i ? want_i : 4'h0;
  end
endmodule // pes_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// testbench: drives the supervisor pins and checks its outputs
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 4; // shortened oscillator divider
  localparam logic [11:0] L1 [4] = '{pes_pkg::MV_1300, pes_pkg::MV_2800,
    pes_pkg::MV_1300, pes_pkg::MV_1800};
  localparam logic [11:0] L2 [4] = '{pes_pkg::MV_3300, pes_pkg::MV_3300,
    pes_pkg::MV_1800, pes_pkg::MV_3300};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  pes_pkg::pes_analog_t an = '0; // comparator inputs
  pes_pkg::pes_volt_t volt;
  logic [3:0] want = 4'h0;
  logic [3:0] pins;
  logic [1:0] lsel = 2'h0; // linear selects b, a
  logic warm = 1'b0;
  logic [7:0] ctl = 8'h00;
  logic [7:0] dis = 8'h00;
  logic [11:0] wd = 12'h000;
  logic [4:0] we = 5'h0; // mask, enable, lin one, lin two, buck1
  logic [2:0] en_o, sw_o, ss_o, dc_o;
  logic [1:0] lin_o;
  logic [4:0] cmp_o;
  logic [7:0] st, mask, enb;
  logic lr_o, on_o, sf_o, bl_o, int_n, rout, roe_n, rline;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n;
  // clock and pulled-up reset line
  always #5 mclk_i = ~mclk_i;
  assign rline = roe_n ? 1'b1 : rout;
  pes_supervisor #(.RESET_TICKS(5), .WARM_TICKS(3), .LF_DIV(DIV))
  i_pes_supervisor (.mclk_i(mclk_i), .rst_i(rst_i), .analog_i(an),
    .buck1_enable_pin_i(pins[0]), .buck2_enable_pin_i(pins[1]),
    .buck3_enable_pin_i(pins[2]), .linear_regs_enable_pin_i(pins[3]),
    .buck1_default_sel_i(1'b1), .buck2_default_sel_i(1'b0),
    .buck3_default_sel_i(1'b1), .linear_default_sel_a_i(lsel[0]),
    .linear_default_sel_b_i(lsel[1]), .warm_reset_in_i(warm),
    .converter_control_reg_i(ctl), .discharge_control_reg_i(dis),
    .mask_wdata_i(wd[7:0]), .mask_we_i(we[0]), .enable_wdata_i(wd[7:0]),
    .enable_we_i(we[1]), .lin_one_wdata_i(wd), .lin_one_we_i(we[2]),
    .lin_two_wdata_i(wd), .lin_two_we_i(we[3]), .buck1_wdata_i(wd),
    .buck1_we_i(we[4]), .buck_enable_o(en_o), .buck_switch_o(sw_o),
    .buck_soft_start_o(ss_o), .buck_discharge_o(dc_o),
    .low_ripple_o(lr_o), .linear_enable_o(lin_o), .comparator_on_o(cmp_o),
    .volt_o(volt), .power_not_good_status_o(st), .mask_o(mask),
    .enable_bits_o(enb), .on_mode_o(on_o), .supply_fail_flag_o(sf_o),
    .battery_low_flag_o(bl_o), .int_n_o(int_n), .system_reset_out_o(rout),
    .system_reset_out_oe_n_o(roe_n));
  pes_host i_pes_host (.mclk_i(mclk_i), .want_i(want),
    .reset_line_i(rline), .pins_o(pins));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // let k edges pass, then sample settled outputs
  task automatic sett(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask
  // one-cycle write strobe k with data d
  task automatic wr(input int k, input logic [11:0] d);
    @(posedge mclk_i);
    wd <= d;
    we <= 5'h01 << k;
    @(posedge mclk_i);
    we <= 5'h00;
  endtask
  // wait for the reset line to be released, bounded
  task automatic wait_free;
    n = 0;
    while (roe_n !== 1'b1 && n < 60) begin
      sett(1);
      n++;
    end
    chk(roe_n, 1'b1);
  endtask
  // print counts and verdict, then stop
  task automatic close_out;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      errors++;
      close_out;
    end
  end
  initial begin
    // power-up once per linear select pattern
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      rst_i <= 1'b1;
      lsel <= 2'(i);
      an.clock_rail_ok <= 1'b0;
      sett(6);
      rst_i <= 1'b0;
      an.clock_rail_ok <= 1'b1;
      sett(15);
      chk(roe_n, 1'b0);
      wait_free;
      chk(volt.lin_one, L1[i]);
      chk(volt.lin_two, L2[i]);
    end
    chk(volt.buck1, pes_pkg::MV_1600);
    chk({volt.buck2, volt.buck3}, {pes_pkg::MV_1800, pes_pkg::MV_3300});
    chk({enb, mask}, 16'hFFC0);
    $display("test power-up done");
    // buck1 start: bias wait, then soft-start ramp
    want <= 4'hF;
    sett(3);
    chk({lin_o, en_o}, 5'h1F);
    n = 0;
    while (ss_o[2] !== 1'b1 && n < 60) begin
      sett(1);
      n++;
    end
    chk(n >= (pes_pkg::BIAS_TICKS - 1) * DIV - 3, 1'b1);
    chk(n <= pes_pkg::BIAS_TICKS * DIV + 2, 1'b1);
    chk(sw_o[2], 1'b1);
    n = 0;
    while (ss_o[2] === 1'b1 && n < 200) begin
      sett(1);
      n++;
    end
    chk(n >= (pes_pkg::SOFT_TICKS - 1) * DIV, 1'b1);
    chk(n <= pes_pkg::SOFT_TICKS * DIV + 3, 1'b1);
    $display("test soft start done");
    // rail faults, masking and flags
    an.rail_low <= 5'h1F;
    sett(3);
    chk({st[5:1], int_n}, 6'h3E);
    wr(0, 12'h03E);
    sett(2);
    chk({mask, int_n}, 9'h07D);
    wr(0, 12'h0C0);
    an.rail_low <= 5'h00;
    an.supply_fail <= 1'b1;
    sett(3);
    chk({st[7], sf_o, int_n}, 3'h7);
    an.supply_fail <= 1'b0;
    an.battery_low <= 1'b1;
    sett(3);
    chk({st[7:6], bl_o}, 3'h3);
    an.battery_low <= 1'b0;
    want <= 4'h0;
    an.rail_low <= 5'h1F;
    sett(4);
    chk({cmp_o, st[5:1], int_n}, 11'h000);
    want <= 4'hF;
    an.rail_low <= 5'h00;
    $display("test status done");
    // software enable bits against pins
    wr(1, 12'h0D9);
    sett(2);
    chk({enb, en_o[2], lin_o}, 11'h6C8);
    want <= 4'hE;
    sett(3);
    chk(enb, 8'hF9);
    want <= 4'hF;
    wr(1, 12'h0FF);
    sett(3);
    chk({en_o, lin_o}, 5'h1F);
    $display("test enable done");
    // low ripple selection
    foreach (L1[i]) begin
      ctl <= 8'h08 ^ (8'hF7 * 8'(i));
      sett(2);
      chk(lr_o, ctl[3]);
    end
    // voltage writes, then warm resets short and long
    wr(2, 12'h456);
    wr(3, 12'h789);
    wr(4, 12'h3E8);
    sett(1);
    chk({volt.lin_one, volt.lin_two, volt.buck1}, 36'h4567893E8);
    warm <= 1'b1;
    sett(4);
    warm <= 1'b0;
    sett(10);
    chk(roe_n, 1'b1);
    warm <= 1'b1;
    sett(3 * DIV + 6);
    chk(roe_n, 1'b0);
    chk({volt.buck1, volt.lin_one}, {pes_pkg::MV_1600, 12'h456});
    warm <= 1'b0;
    wait_free;
    $display("test warm reset done");
    // lockout and overheat with discharge on
    dis <= 8'h07;
    wr(0, 12'h03E);
    an.supply_low <= 1'b1;
    sett(3);
    chk({en_o, lin_o, on_o, dc_o}, 9'h007);
    chk({enb, mask}, 16'hFFC0);
    an.supply_low <= 1'b0;
    an.over_temp <= 1'b1;
    sett(2);
    chk({en_o, lin_o, dc_o}, 8'h07);
    an.over_temp <= 1'b0;
    $display("test lockout done");
    close_out;
  end
endmodule // tb_top
bind pes_supervisor pes_sva i_pes_sva (.mclk_i(mclk_i), .rst_i(rst_i),
  .analog_i(analog_i), .buck1_enable_pin_i(buck1_enable_pin_i),
  .warm_reset_in_i(warm_reset_in_i),
  .converter_control_reg_i(converter_control_reg_i),
  .discharge_control_reg_i(discharge_control_reg_i),
  .buck_enable_o(buck_enable_o), .buck_discharge_o(buck_discharge_o),
  .low_ripple_o(low_ripple_o), .linear_enable_o(linear_enable_o),
  .comparator_on_o(comparator_on_o),
  .power_not_good_status_o(power_not_good_status_o), .int_n_o(int_n_o),
  .on_mode_o(on_mode_o), .system_reset_out_o(system_reset_out_o),
  .system_reset_out_oe_n_o(system_reset_out_oe_n_o));
`default_nettype wire
